/* File: rtl/prw_map.vh */
// Constants for the paged RAM window bus glue.
`ifndef PRW_MAP_VH
`define PRW_MAP_VH
`define PRW_PAGE_ADDR 16'h2220
`define PRW_HI_LSB 8
`define PRW_LO_LSB 0
`define PRW_PAGE_W 5
`define PRW_PAGE_RST 5'h00
`define PRW_LO_WIN_BASE 20'h80000
`define PRW_HI_WIN_BASE 20'ha0000
`define PRW_WIN_SEL_LSB 17
`define PRW_PAGE_MAX_BASE 5'h0f
`define PRW_PAGE_MAX_EXP 5'h17
`define PRW_WD_TIMEOUT_NS 10000
`define PRW_CLK_PERIOD_NS 4
`endif

/* File: rtl/prw_watchdog.v */
// Bus cycle watchdog that forces ready after a quiet period.
`timescale 1ns/1ns
module prw_watchdog #(
  parameter COUNT = 2500
)(
  input wire clock_i,
  input wire rst_n_i,
  input wire cycle_start_i,
  input wire cycle_done_i,
  output reg force_ready_o
);
  reg [15:0] count_reg;
  reg pending_reg;

  // A new cycle restarts the count; expiry with a cycle pending ends it.
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      count_reg <= 16'h0000;
      pending_reg <= 1'b0;
      force_ready_o <= 1'b0;
    end
    else if (cycle_start_i)
    begin
      count_reg <= 16'h0000;
      pending_reg <= 1'b1;
      force_ready_o <= 1'b0;
    end
    else if (pending_reg && (cycle_done_i || force_ready_o))
    begin
      pending_reg <= 1'b0;
      force_ready_o <= 1'b0;
    end
    else if (pending_reg)
    begin
      count_reg <= count_reg + 16'h0001;
      force_ready_o <= (count_reg == COUNT[15:0] - 16'h0001);
    end
    else
    begin
      force_ready_o <= 1'b0;
    end
  end
endmodule // prw_watchdog

/* File: rtl/prw_glue.v */
// Paged RAM window glue: page register, address mapping, watchdog, interrupt and DMA routing.
`timescale 1ns/1ns
`include "prw_map.vh"
module prw_glue #(
  parameter WD_COUNT = `PRW_WD_TIMEOUT_NS / `PRW_CLK_PERIOD_NS
)(
  input wire clock_i,
  input wire rst_n_i,
  // Host local bus.
  input wire [19:0] bus_addr_i,
  input wire io_cycle_i,
  input wire mem_cycle_i,
  input wire bus_start_i,
  input wire wr_i,
  input wire rd_i,
  input wire [15:0] wdata_i,
  input wire dev_ready_i,
  output reg [15:0] rdata_o,
  output reg ready_o,
  // Paged RAM.
  input wire ram_expansion_present_n_i,
  output reg [20:0] paged_addr_o,
  output reg paged_sel_o,
  output reg ram_expansion_present_n_o,
  // Interrupt and DMA sources.
  input wire serial_controller_irq_i,
  input wire option_irq0_i,
  input wire coax_fifo_irq_i,
  input wire panel_irq_i,
  input wire floppy_controller_irq_i,
  input wire option_irq3_i,
  input wire option_nmi_i,
  input wire int0_ack_i,
  input wire serial_controller_drq_i,
  input wire floppy_controller_drq_i,
  input wire option_drq0_i,
  input wire option_drq1_i,
  output reg int0_o,
  output reg int1_o,
  output reg int2_o,
  output reg int3_o,
  output reg nmi_o,
  output reg drq0_o,
  output reg drq1_o
);
  // ***********************************************
  // Page register
  // ***********************************************
  reg [4:0] high_window_page_reg;
  reg [4:0] low_window_page_reg;
  wire page_hit;
  wire force_ready;

  assign page_hit = io_cycle_i && (bus_addr_i[15:0] == `PRW_PAGE_ADDR);

  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      high_window_page_reg <= `PRW_PAGE_RST;
      low_window_page_reg <= `PRW_PAGE_RST;
    end
    else if (page_hit && wr_i)
    begin
      high_window_page_reg <= wdata_i[`PRW_HI_LSB+4:`PRW_HI_LSB];
      low_window_page_reg <= wdata_i[`PRW_LO_LSB+4:`PRW_LO_LSB];
    end
  end

  // ***********************************************
  // Window mapping
  // ***********************************************
  reg [4:0] page_sel;
  reg [4:0] page_max;
  reg [5:0] blk;
  reg [4:0] blk_wrap;
  reg in_win;

  always @*
  begin
    in_win = mem_cycle_i && (bus_addr_i[19:18] == 2'b10);
    page_sel = bus_addr_i[`PRW_WIN_SEL_LSB] ? high_window_page_reg : low_window_page_reg;
    page_max = ram_expansion_present_n_i ? `PRW_PAGE_MAX_BASE : `PRW_PAGE_MAX_EXP;
    blk = {1'b0, page_sel} + {5'h00, bus_addr_i[16]};
    if (blk > {1'b0, page_max})
      blk_wrap = 5'h00;
    else
      blk_wrap = blk[4:0];
  end

  // ***********************************************
  // Next values for the bus answers
  // ***********************************************
  wire [15:0] rdata_next;
  wire [20:0] paged_addr_next;
  wire paged_sel_next;
  wire ready_next;
  wire ram_expansion_present_n_next;

  // Only a read of the page register drives data; the unused bits read as zero.
  assign rdata_next = (page_hit && rd_i) ?
    {3'h0, high_window_page_reg, 3'h0, low_window_page_reg} : 16'h0000;
  assign paged_addr_next = {blk_wrap, bus_addr_i[15:0]};
  assign paged_sel_next = in_win;
  // Window accesses end at once; other cycles wait for the device or the watchdog.
  assign ready_next = dev_ready_i || force_ready ||
    (in_win && (rd_i || wr_i));
  assign ram_expansion_present_n_next = ram_expansion_present_n_i;

  // ***********************************************
  // Next values for interrupt and DMA routing
  // ***********************************************
  wire int0_next;
  wire int1_next;
  wire int2_next;
  wire int3_next;
  wire nmi_next;
  wire drq0_next;
  wire drq1_next;

  // Requests are level signals, so they are only merged and registered.
  assign int0_next = serial_controller_irq_i || option_irq0_i;
  assign int1_next = coax_fifo_irq_i;
  assign int2_next = int0_ack_i;
  assign int3_next = panel_irq_i || floppy_controller_irq_i || option_irq3_i;
  assign nmi_next = option_nmi_i;
  assign drq0_next = serial_controller_drq_i || option_drq0_i;
  assign drq1_next = floppy_controller_drq_i || option_drq1_i;

  // ***********************************************
  // Bus answers
  // ***********************************************
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o <= 16'h0000;
      ready_o <= 1'b0;
      paged_addr_o <= 21'h00000;
      paged_sel_o <= 1'b0;
      ram_expansion_present_n_o <= 1'b1;
    end
    else
    begin
      rdata_o <= rdata_next;
      paged_addr_o <= paged_addr_next;
      paged_sel_o <= paged_sel_next;
      ready_o <= ready_next;
      ram_expansion_present_n_o <= ram_expansion_present_n_next;
    end
  end

  // ***********************************************
  // Interrupt and DMA routing
  // ***********************************************
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      int0_o <= 1'b0;
      int1_o <= 1'b0;
      int2_o <= 1'b0;
      int3_o <= 1'b0;
      nmi_o <= 1'b0;
      drq0_o <= 1'b0;
      drq1_o <= 1'b0;
    end
    else
    begin
      int0_o <= int0_next;
      int1_o <= int1_next;
      int2_o <= int2_next;
      int3_o <= int3_next;
      nmi_o <= nmi_next;
      drq0_o <= drq0_next;
      drq1_o <= drq1_next;
    end
  end

  // ***********************************************
  // Bus watchdog
  // ***********************************************

  // The timeout is kept well below the 15.2 us refresh interval.
  prw_watchdog #(
    .COUNT(WD_COUNT)
  ) u_wd (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .cycle_start_i(bus_start_i),
    .cycle_done_i(dev_ready_i),
    .force_ready_o(force_ready)
  );
endmodule // prw_glue

/* File: verif/prw_glue_sva.sv */
// Checker for the paged RAM window glue.
`timescale 1ns/1ns
module prw_glue_sva(input wire clock_i, rst_n_i, io_cycle_i, mem_cycle_i, wr_i, rd_i,
  bus_start_i, dev_ready_i, ready_o, paged_sel_o, ram_expansion_present_n_i,
  ram_expansion_present_n_o, serial_controller_irq_i, option_irq0_i, coax_fifo_irq_i,
  panel_irq_i, floppy_controller_irq_i, option_irq3_i, option_nmi_i, int0_ack_i,
  serial_controller_drq_i, option_drq0_i, floppy_controller_drq_i, option_drq1_i,
  int0_o, int1_o, int2_o, int3_o, nmi_o, drq0_o, drq1_o,
  input wire [19:0] bus_addr_i, input wire [15:0] wdata_i, rdata_o,
  input wire [20:0] paged_addr_o);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  wire pg = io_cycle_i && bus_addr_i[15:0] == 16'h2220;
  wire win = mem_cycle_i && bus_addr_i[19:18] == 2'b10;
  sequence pg_wr; pg && wr_i; endsequence
  sequence pg_rd; pg && rd_i; endsequence
  int_route_a: assert property ($past(rst_n_i) |->
    {int0_o, int1_o, int2_o, int3_o, nmi_o} == $past({serial_controller_irq_i | option_irq0_i,
    coax_fifo_irq_i, int0_ack_i, panel_irq_i | floppy_controller_irq_i | option_irq3_i,
    option_nmi_i})) else $error("irq route");
  dma_route_a: assert property ($past(rst_n_i) |-> {drq0_o, drq1_o} ==
    $past({serial_controller_drq_i | option_drq0_i, floppy_controller_drq_i | option_drq1_i}))
    else $error("dma route");
  page_mask_a: assert property (pg_rd |=> rdata_o[15:13] == 0 && rdata_o[7:5] == 0)
    else $error("page mask");
  page_rw_a: assert property (pg_wr ##1 pg_rd |=> rdata_o == ($past(wdata_i, 2) & 16'h1f1f))
    else $error("page readback");
  win_hit_a: assert property (win |=> paged_sel_o && ready_o) else $error("window hit");
  win_off_a: assert property (win |=> paged_addr_o[15:0] == $past(bus_addr_i[15:0]))
    else $error("window offset");
  wd_fire_a: assert property ($rose(bus_start_i) ##1 (!bus_start_i && !dev_ready_i)[*3]
    |-> ##[1:40] ready_o) else $error("watchdog");
  exp_flag_a: assert property ($past(rst_n_i) |->
    ram_expansion_present_n_o == $past(ram_expansion_present_n_i)) else $error("flag");
endmodule // prw_glue_sva
bind prw_glue prw_glue_sva i_sva(.*);

/* File: verif/prw_host.sv */
// Host processor model that runs local bus cycles.
`timescale 1ns/1ns
module prw_host(input wire clock_i, output reg [19:0] bus_addr_i, output reg [15:0] wdata_i,
  output reg io_cycle_i, mem_cycle_i, bus_start_i, wr_i, rd_i);
  initial {bus_addr_i, wdata_i, io_cycle_i, mem_cycle_i, bus_start_i, wr_i, rd_i} = 0;
  // The model is a host already set up before its first cycle here.
  // With s low the bus is released and the data lines show the inverse of the last value.
  task cyc(input s, input io, input w, input [19:0] a, input [15:0] d);
    begin
      {bus_addr_i, io_cycle_i, mem_cycle_i, bus_start_i, wr_i, rd_i} = {a, {s, s, s, s, s} &
        {io, !io, 1'b1, w, !w}};
      wdata_i = s ? d : ~wdata_i;
      @(posedge clock_i);
      #1;
    end
  endtask
endmodule // prw_host

/* File: verif/testbench.sv */
// Self-checking bench for the paged RAM window glue.
`timescale 1ns/1ns
module testbench;
  reg clock_i = 0, rst_n_i = 0, dev_ready_i = 0, ram_expansion_present_n_i = 1;
  reg [11:0] src = 0;
  reg [17:0] a;
  wire [19:0] bus_addr_i;
  wire [15:0] wdata_i, rdata_o;
  wire [20:0] paged_addr_o;
  wire io_cycle_i, mem_cycle_i, bus_start_i, wr_i, rd_i, ready_o, paged_sel_o;
  wire ram_expansion_present_n_o, int0_o, int1_o, int2_o, int3_o, nmi_o, drq0_o, drq1_o;
  integer seed = 32'h3f32, miscompares = 0, check_count = 0, n, k, hp, lp, mx;
  always #2 clock_i = ~clock_i;
  prw_host i_prw_host(.*);
  prw_glue #(.WD_COUNT(20)) i_prw_glue(.*, .serial_controller_irq_i(src[0]),
    .option_irq0_i(src[1]), .coax_fifo_irq_i(src[2]), .panel_irq_i(src[3]),
    .floppy_controller_irq_i(src[4]), .option_irq3_i(src[5]), .option_nmi_i(src[6]),
    .int0_ack_i(src[7]), .serial_controller_drq_i(src[8]), .option_drq0_i(src[9]),
    .floppy_controller_drq_i(src[10]), .option_drq1_i(src[11]));
  task chk(input [20:0] e, input [20:0] g);
    begin
      check_count = check_count + 1;
      if (e !== g)
      begin
        miscompares = miscompares + 1;
        $display("mismatch %0t exp %h got %h", $time, e, g);
      end
    end
  endtask
  task summarize;
    begin
      if (miscompares == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial
  begin
    repeat (3) @(posedge clock_i);
    #1 rst_n_i = 1;
    i_prw_host.cyc(1, 1, 0, 20'h02220, 0);
    chk(0, rdata_o);
    for (k = 0; k < 24; k = k + 1)
    begin
      ram_expansion_present_n_i = k[0];
      mx = k[0] ? 15 : 23;
      hp = k < 2 ? mx : {$random(seed)} % (mx + 1);
      lp = k < 2 ? mx : {$random(seed)} % (mx + 1);
      n = $random(seed);
      src = n[11:0];
      i_prw_host.cyc(1, 1, 1, 20'h02220, {3'h7, hp[4:0], 3'h7, lp[4:0]});
      i_prw_host.cyc(1, 1, 0, 20'h02220, 0);
      chk({hp[4:0], 3'h0, lp[4:0]}, rdata_o);
      chk({src[0] | src[1], src[2], src[7], |src[5:3], src[6], src[8] | src[9],
        src[10] | src[11]}, {int0_o, int1_o, int2_o, int3_o, nmi_o, drq0_o, drq1_o});
      chk(k[0], ram_expansion_present_n_o);
      n = $random(seed);
      a = {n[17], k < 2 || n[16], n[15:0]};
      i_prw_host.cyc(1, 0, n[0], {2'b10, a}, n[31:16]);
      n = (a[17] ? hp : lp) + a[16];
      if (n > mx) n = 0;
      chk({n[4:0], a[15:0]}, paged_addr_o);
      chk(2'b11, {paged_sel_o, ready_o});
    end
    i_prw_host.cyc(0, 0, 0, 0, 0);
    i_prw_host.cyc(1, 1, 0, 20'h02380, 0);
    chk(0, rdata_o);
    i_prw_host.cyc(0, 0, 0, 0, 0);
    n = 1;
    while (ready_o !== 1'b1 && n < 40)
    begin
      @(posedge clock_i);
      #1 n = n + 1;
    end
    chk(1, n >= 19 && n <= 22);
    summarize;
  end
endmodule // testbench
